//--- src/bwlm_pkg.sv
// Shared constants for the burst write lane-mask block
package bwlm_pkg;

    // ------------------------------------------------------------------
    // Organisation and lane geometry
    // ------------------------------------------------------------------
    localparam int BWLM_DEF_DATA_W  = 18;
    localparam int BWLM_DEF_ADDR_W  = 20;
    localparam int BWLM_ORG_NIBBLE  = 8;
    localparam int BWLM_NIBBLE_W    = 4;
    localparam int BWLM_LANE9_W     = 9;
    localparam int BWLM_SYNC_STAGES = 2;

    // ------------------------------------------------------------------
    // Burst layout: beat 0 sits in the low half of a stored pair
    // ------------------------------------------------------------------
    localparam int BWLM_BEAT0_OFS = 0;
    localparam int BWLM_BEAT1_OFS = 1;
    localparam int BWLM_BEATS     = 2;

    // ------------------------------------------------------------------
    // Reset values and strap timing
    // ------------------------------------------------------------------
    localparam logic       BWLM_OE_RST        = 1'b0;
    localparam logic       BWLM_SINGLE_RST    = 1'b0;
    localparam logic [1:0] BWLM_STRAP_CAPTURE = 2'h3;

    // ------------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        BWLM_W_IDLE,
        BWLM_W_BEAT1,
        BWLM_W_COMMIT
    } bwlm_wr_state_t;

    typedef enum logic [1:0] {
        BWLM_R_IDLE,
        BWLM_R_WAIT0,
        BWLM_R_BEAT0,
        BWLM_R_BEAT1
    } bwlm_rd_state_t;

endpackage

//--- src/bwlm_sync.sv
// Two-stage synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
`default_nettype none
module bwlm_sync
    import bwlm_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);

    // ------------------------------------------------------------------
    // First stage feeds only the second stage
    // ------------------------------------------------------------------
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule
`default_nettype wire

//--- src/bwlm_mem.sv
// Pair-wide array with per-bit write enables and registered read
`timescale 1ns/1ps
`default_nettype none
module bwlm_mem
    import bwlm_pkg::*;
#(
    parameter int ADDR_W = BWLM_DEF_ADDR_W,
    parameter int WORD_W = 2 * BWLM_DEF_DATA_W
) (
    input  wire logic              clock,
    input  wire logic              wr_valid,
    input  wire logic [ADDR_W-1:0] wr_addr,
    input  wire logic [WORD_W-1:0] wr_data,
    input  wire logic [WORD_W-1:0] wr_bit_en,
    input  wire logic              rd_valid,
    input  wire logic [ADDR_W-1:0] rd_addr,
    output var  logic [WORD_W-1:0] rd_data
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [WORD_W-1:0] mem_q [2**ADDR_W];

    // Disabled bits keep their content, so no read-modify-write is needed
    always_ff @(posedge clock) begin
        if (wr_valid) begin
            for (int i = 0; i < WORD_W; i++) begin
                if (wr_bit_en[i]) begin
                    mem_q[wr_addr][i] <= wr_data[i];
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rd_valid) begin
            rd_data <= mem_q[rd_addr];
        end
    end

endmodule
`default_nettype wire

//--- src/bwlm_top.sv
// Two-beat DDR SRAM write port with lane masking and read launch
// ----------------------------------------------------------------------
// Overview of operation
// - Data and selects registered on both edges
// - Beats go to base plus zero, one
// - Eight-bit: nibble selects gate each nibble
// - Eighteen-bit: two selects gate nine-bit lanes
// - Both selects high writes nothing that beat
// - Nine-bit: one select gates whole beat
// - Thirty-six-bit: all selects low writes all
// - Thirty-six-bit: four selects map nine-bit lanes
// - All selects high writes nothing that beat
// - Selects evaluated independently for each beat
// - Powers up deselected, read outputs tri-stated
// - Read data launched on output clock pair, or on input clock pair in single-clock mode
// ----------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module bwlm_top
    import bwlm_pkg::*;
#(
    parameter int DATA_W = BWLM_DEF_DATA_W,
    parameter int ADDR_W = BWLM_DEF_ADDR_W,
    parameter int LANE_W = (DATA_W == BWLM_ORG_NIBBLE) ? BWLM_NIBBLE_W : BWLM_LANE9_W,
    parameter int LANE_N = DATA_W / LANE_W
) (
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic              in_edge_pos,
    input  wire logic              in_edge_neg,
    input  wire logic              output_timing_pos,
    input  wire logic              output_timing_neg,
    input  wire logic              write_port_select_n,
    input  wire logic              read_port_select_n,
    input  wire logic [ADDR_W-1:0] address,
    input  wire logic [DATA_W-1:0] write_data,
    input  wire logic [LANE_N-1:0] lane_write_mask_n,
    output var  logic [DATA_W-1:0] read_data,
    output var  logic              read_data_oe,
    output var  logic              single_clock_mode
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    localparam int SYNC_W = 6 + ADDR_W + DATA_W + LANE_N;
    localparam int WORD_W = BWLM_BEATS * DATA_W;

    logic [SYNC_W-1:0] pins_raw;
    logic [SYNC_W-1:0] pins_s;
    logic              kp_s;
    logic              kn_s;
    logic              cp_s;
    logic              cn_s;
    logic              wps_n_s;
    logic              rps_n_s;
    logic [ADDR_W-1:0] addr_s;
    logic [DATA_W-1:0] data_s;
    logic [LANE_N-1:0] mask_n_s;

    assign pins_raw = {in_edge_pos, in_edge_neg, output_timing_pos, output_timing_neg,
                       write_port_select_n, read_port_select_n, address, write_data,
                       lane_write_mask_n};

    // Data shares the clock pins' latency so each edge sees its own beat
    bwlm_sync #(
        .WIDTH (SYNC_W)
    ) u_sync (
        .clock    (clock),
        .rst      (rst),
        .async_in (pins_raw),
        .sync_out (pins_s)
    );

    assign {kp_s, kn_s, cp_s, cn_s, wps_n_s, rps_n_s, addr_s, data_s, mask_n_s} = pins_s;

    // ------------------------------------------------------------------
    // Edge detection on the sampled clock pins
    // ------------------------------------------------------------------
    logic kp_d1_q;
    logic kn_d1_q;
    logic cp_d1_q;
    logic cn_d1_q;
    logic kp_rise;
    logic kn_rise;
    logic cp_rise;
    logic cn_rise;
    logic out_pos_rise;
    logic out_neg_rise;

    // Parked-high clocks show one false edge; the strap wait hides it
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            kp_d1_q <= 1'b0;
            kn_d1_q <= 1'b0;
            cp_d1_q <= 1'b0;
            cn_d1_q <= 1'b0;
        end else begin
            kp_d1_q <= kp_s;
            kn_d1_q <= kn_s;
            cp_d1_q <= cp_s;
            cn_d1_q <= cn_s;
        end
    end

    assign kp_rise = kp_s & ~kp_d1_q;
    assign kn_rise = kn_s & ~kn_d1_q;
    assign cp_rise = cp_s & ~cp_d1_q;
    assign cn_rise = cn_s & ~cn_d1_q;

    // ------------------------------------------------------------------
    // Single-clock strap
    // ------------------------------------------------------------------
    logic [1:0] strap_cnt_q;
    logic       strap_done_q;

    // Sampled after the synchronisers have filled; fixed until next reset
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            strap_cnt_q       <= 2'h0;
            strap_done_q      <= 1'b0;
            single_clock_mode <= BWLM_SINGLE_RST;
        end else if (!strap_done_q) begin
            strap_cnt_q <= strap_cnt_q + 2'h1;
            if (strap_cnt_q == BWLM_STRAP_CAPTURE) begin
                strap_done_q      <= 1'b1;
                single_clock_mode <= cp_s & cn_s;
            end
        end
    end

    assign out_pos_rise = single_clock_mode ? kp_rise : cp_rise;
    assign out_neg_rise = single_clock_mode ? kn_rise : cn_rise;

    // ------------------------------------------------------------------
    // Lane decoding
    // ------------------------------------------------------------------
    // One function covers 8, 9, 18 and 36 bits: lane width sets the split
    function automatic logic [DATA_W-1:0] lane_bits(input logic [LANE_N-1:0] sel_n);
        logic [DATA_W-1:0] en;
        en = '0;
        for (int i = 0; i < DATA_W; i++) begin
            en[i] = ~sel_n[i / LANE_W];
        end
        return en;
    endfunction

    // ------------------------------------------------------------------
    // Write sequencer
    // ------------------------------------------------------------------
    bwlm_wr_state_t    wr_state_q;
    logic [DATA_W-1:0] beat0_data_q;
    logic [DATA_W-1:0] beat1_data_q;
    logic [DATA_W-1:0] beat0_en_q;
    logic [DATA_W-1:0] beat1_en_q;
    logic [ADDR_W-1:0] wr_addr_q;
    logic              wr_start;
    logic              commit;

    assign wr_start = kp_rise & ~wps_n_s & strap_done_q;
    assign commit   = (wr_state_q == BWLM_W_COMMIT);

    // A new burst may begin in the commit cycle; the pair is already held
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_state_q <= BWLM_W_IDLE;
        end else begin
            unique case (wr_state_q)
                BWLM_W_IDLE: begin
                    if (wr_start) begin
                        wr_state_q <= BWLM_W_BEAT1;
                    end
                end
                BWLM_W_BEAT1: begin
                    if (kn_rise) begin
                        wr_state_q <= BWLM_W_COMMIT;
                    end
                end
                BWLM_W_COMMIT: begin
                    wr_state_q <= wr_start ? BWLM_W_BEAT1 : BWLM_W_IDLE;
                end
            endcase
        end
    end

    // Each beat keeps its own mask, so selects may differ between beats
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            beat0_data_q <= '0;
            beat0_en_q   <= '0;
        end else if (wr_start && wr_state_q != BWLM_W_BEAT1) begin
            beat0_data_q <= data_s;
            beat0_en_q   <= lane_bits(mask_n_s);
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            beat1_data_q <= '0;
            beat1_en_q   <= '0;
            wr_addr_q    <= '0;
        end else if (wr_state_q == BWLM_W_BEAT1 && kn_rise) begin
            beat1_data_q <= data_s;
            beat1_en_q   <= lane_bits(mask_n_s);
            wr_addr_q    <= addr_s;
        end
    end

    // ------------------------------------------------------------------
    // Array
    // ------------------------------------------------------------------
    bwlm_rd_state_t    rd_state_q;
    logic [ADDR_W-1:0] rd_addr_q;
    logic              rd_fetch_q;
    logic [WORD_W-1:0] rd_word;
    logic [WORD_W-1:0] wr_word;
    logic [WORD_W-1:0] wr_word_en;
    logic              rd_start;

    // Base plus one in the upper half, base plus zero in the lower half
    assign wr_word    = {beat1_data_q, beat0_data_q};
    assign wr_word_en = {beat1_en_q, beat0_en_q};

    bwlm_mem #(
        .ADDR_W (ADDR_W),
        .WORD_W (WORD_W)
    ) u_mem (
        .clock     (clock),
        .wr_valid  (commit),
        .wr_addr   (wr_addr_q),
        .wr_data   (wr_word),
        .wr_bit_en (wr_word_en),
        .rd_valid  (rd_fetch_q),
        .rd_addr   (rd_addr_q),
        .rd_data   (rd_word)
    );

    // ------------------------------------------------------------------
    // Read launch
    // ------------------------------------------------------------------
    // A read of a pair still in commit sees the old content; no forwarding
    assign rd_start = kp_rise & ~rps_n_s & strap_done_q;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rd_addr_q  <= '0;
            rd_fetch_q <= 1'b0;
        end else begin
            rd_fetch_q <= rd_start;
            if (rd_start) begin
                rd_addr_q <= addr_s;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rd_state_q <= BWLM_R_IDLE;
        end else begin
            unique case (rd_state_q)
                BWLM_R_IDLE: begin
                    if (rd_start) begin
                        rd_state_q <= BWLM_R_WAIT0;
                    end
                end
                BWLM_R_WAIT0: begin
                    if (out_neg_rise && !rd_fetch_q) begin
                        rd_state_q <= BWLM_R_BEAT0;
                    end
                end
                BWLM_R_BEAT0: begin
                    if (out_pos_rise) begin
                        rd_state_q <= BWLM_R_BEAT1;
                    end
                end
                BWLM_R_BEAT1: begin
                    if (out_neg_rise) begin
                        rd_state_q <= rd_start ? BWLM_R_WAIT0 : BWLM_R_IDLE;
                    end
                end
            endcase
        end
    end

    // Outputs float except while a beat is on the bus
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            read_data    <= '0;
            read_data_oe <= BWLM_OE_RST;
        end else begin
            unique case (rd_state_q)
                BWLM_R_WAIT0: begin
                    if (out_neg_rise && !rd_fetch_q) begin
                        read_data    <= rd_word[BWLM_BEAT0_OFS*DATA_W +: DATA_W];
                        read_data_oe <= 1'b1;
                    end
                end
                BWLM_R_BEAT0: begin
                    if (out_pos_rise) begin
                        read_data <= rd_word[BWLM_BEAT1_OFS*DATA_W +: DATA_W];
                    end
                end
                BWLM_R_BEAT1: begin
                    if (out_neg_rise) begin
                        read_data_oe <= 1'b0;
                    end
                end
                BWLM_R_IDLE: begin
                    read_data_oe <= 1'b0;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

//--- test/bwlm_props.sv
// Port-level checker for the lane-mask write block
`timescale 1ns/1ps
`default_nettype none
module bwlm_props
    import bwlm_pkg::*;
#(
    parameter int DATA_W = 18,
    parameter int ADDR_W = 20,
    parameter int LANE_N = 2
) (
    input wire logic              clock,
    input wire logic              rst,
    input wire logic              in_edge_pos,
    input wire logic              in_edge_neg,
    input wire logic              output_timing_pos,
    input wire logic              output_timing_neg,
    input wire logic              write_port_select_n,
    input wire logic              read_port_select_n,
    input wire logic [ADDR_W-1:0] address,
    input wire logic [DATA_W-1:0] write_data,
    input wire logic [LANE_N-1:0] lane_write_mask_n,
    input wire logic [DATA_W-1:0] read_data,
    input wire logic              read_data_oe,
    input wire logic              single_clock_mode
);
    localparam int LAT_MIN = 1;
    localparam int LAT_MAX = 6;
    // ------------------------------------------------------------------
    // Helper logic: cycles since each output clock rose
    // ------------------------------------------------------------------
    logic       oc_pos;
    logic       oc_neg;
    logic       pos_q;
    logic       neg_q;
    logic       rd_seen_q;
    logic       strap_q;
    logic [3:0] cnt_p_q;
    logic [3:0] cnt_n_q;
    logic [3:0] rel_q;
    assign oc_pos = single_clock_mode ? in_edge_pos : output_timing_pos;
    assign oc_neg = single_clock_mode ? in_edge_neg : output_timing_neg;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pos_q   <= 1'b1;
            neg_q   <= 1'b1;
            cnt_p_q <= 4'hf;
            cnt_n_q <= 4'hf;
        end else begin
            pos_q   <= oc_pos;
            neg_q   <= oc_neg;
            cnt_p_q <= (oc_pos && !pos_q) ? 4'h0 : cnt_p_q + 4'(cnt_p_q != 4'hf);
            cnt_n_q <= (oc_neg && !neg_q) ? 4'h0 : cnt_n_q + 4'(cnt_n_q != 4'hf);
        end
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rd_seen_q <= 1'b0;
            rel_q     <= 4'h0;
        end else begin
            rd_seen_q <= rd_seen_q || (!read_port_select_n && in_edge_pos);
            rel_q     <= rel_q + 4'(rel_q != 4'h7);
        end
    end
    // Strap pins count only while reset is held
    always_ff @(posedge clock) begin
        if (rst)
            strap_q <= output_timing_pos & output_timing_neg;
    end
    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    a_reset_quiet: assert property (disable iff (1'b0)
        rst |-> !read_data_oe && read_data == '0)
        else $error("outputs active during reset");
    a_oe_cause: assert property ($rose(read_data_oe) |-> rd_seen_q)
        else $error("read outputs enabled without a read");
    a_oe_rise_edge: assert property ($rose(read_data_oe) |->
        cnt_n_q inside {[LAT_MIN:LAT_MAX]})
        else $error("output enable rose away from neg output edge");
    a_oe_fall_edge: assert property ($fell(read_data_oe) |->
        cnt_n_q inside {[LAT_MIN:LAT_MAX]})
        else $error("output enable fell away from neg output edge");
    a_oe_min_width: assert property ($rose(read_data_oe) |-> read_data_oe[*4])
        else $error("output enable shorter than an output cycle");
    a_data_on_edge: assert property ($changed(read_data) |->
        (cnt_p_q inside {[LAT_MIN:LAT_MAX]} || cnt_n_q inside {[LAT_MIN:LAT_MAX]}))
        else $error("read data changed without an output edge");
    a_strap_value: assert property (rel_q == 4'h7 |-> single_clock_mode == strap_q)
        else $error("clock mode differs from strap");
    a_strap_stable: assert property ($past(rel_q) == 4'h7 |-> $stable(single_clock_mode))
        else $error("clock mode changed in operation");
    c_read_burst: cover property ($rose(read_data_oe) ##[1:20] $fell(read_data_oe));
    c_single_mode: cover property (single_clock_mode && $rose(read_data_oe));
    c_data_change: cover property (read_data_oe && $changed(read_data));
endmodule
`default_nettype wire

//--- test/bwlm_ctrl_model.sv
// Behavioural memory controller driving the write and read pins
`timescale 1ns/1ps
`default_nettype none
module bwlm_ctrl_model
    import bwlm_pkg::*;
#(
    parameter int DATA_W = 18,
    parameter int ADDR_W = 6,
    parameter int LANE_N = 2,
    parameter int PH     = 4
) (
    input  wire logic              clock,
    input  wire logic [DATA_W-1:0] read_data,
    input  wire logic              read_data_oe,
    output var  logic              in_edge_pos,
    output var  logic              in_edge_neg,
    output var  logic              output_timing_pos,
    output var  logic              output_timing_neg,
    output var  logic              write_port_select_n,
    output var  logic              read_port_select_n,
    output var  logic [ADDR_W-1:0] address,
    output var  logic [DATA_W-1:0] write_data,
    output var  logic [LANE_N-1:0] lane_write_mask_n
);
    // ------------------------------------------------------------------
    // Pin sequencing; each pin phase lasts PH system clocks, except the high phase in oedge, which lasts PH+1
    // ------------------------------------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // Idle: clock pairs parked high, output_timing_pos at the strap, for a quick restart
    task automatic park(input logic strap);
        in_edge_pos         = 1'b1;
        in_edge_neg         = 1'b1;
        output_timing_pos   = strap; // both high selects single clock
        output_timing_neg   = 1'b1;
        write_port_select_n = 1'b1;
        read_port_select_n  = 1'b1;
        address             = '0;
        write_data          = '0;
        lane_write_mask_n   = '1;
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d0, d1,
                      input logic [LANE_N-1:0] m0, m1, input logic sel_n);
        write_port_select_n = sel_n;
        write_data          = d0;
        lane_write_mask_n   = m0;
        in_edge_pos         = 1'b0;
        step(PH);
        in_edge_pos         = 1'b1; // beat 0 on pos rise
        in_edge_neg         = 1'b0;
        step(PH);
        write_port_select_n = 1'b1;
        address             = a;
        write_data          = d1;
        lane_write_mask_n   = m1; // new selects for beat 1
        step(PH);
        in_edge_neg         = 1'b1; // address and beat 1 on neg rise
        step(PH);
        // Released lines show the inverse
        write_data          = ~d1;
        address             = ~a;
        lane_write_mask_n   = ~m1;
        step(PH);
    endtask
    // One output edge on the chosen pair: low phase, then rise
    task automatic oedge(input logic single, input logic is_pos);
        for (int l = 0; l < 2; l++) begin
            if (single && is_pos)
                in_edge_pos = l[0];
            else if (single)
                in_edge_neg = l[0];
            else if (is_pos)
                output_timing_pos = l[0];
            else
                output_timing_neg = l[0];
            step(PH + l);
        end
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic single,
                      output logic [DATA_W-1:0] q0, q1, output logic [2:0] oe);
        read_port_select_n = 1'b0;
        address = a;
        in_edge_pos = 1'b0;
        step(PH);
        in_edge_pos = 1'b1;
        step(PH);
        read_port_select_n = 1'b1;
        address = ~a;
        oedge(single, 1'b0);
        q0 = read_data;
        oe[0] = read_data_oe;
        oedge(single, 1'b1);
        q1 = read_data;
        oe[1] = read_data_oe;
        oedge(single, 1'b0);
        oe[2] = read_data_oe;
    endtask
endmodule
`default_nettype wire

//--- test/testbench.sv
// Self-checking bench for the lane-mask write block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import bwlm_pkg::*;
    localparam int DATA_W = 18;
    localparam int ADDR_W = 6;
    localparam int LANE_N = 2;
    localparam int LW     = DATA_W / LANE_N;
    logic              clock = 1'b0;
    logic              rst;
    logic              in_edge_pos;
    logic              in_edge_neg;
    logic              output_timing_pos;
    logic              output_timing_neg;
    logic              write_port_select_n;
    logic              read_port_select_n;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] write_data;
    logic [LANE_N-1:0] lane_write_mask_n;
    logic [DATA_W-1:0] read_data;
    logic              read_data_oe;
    logic              single_clock_mode;
    logic [DATA_W-1:0] exp_mem [2**ADDR_W][2];
    int                err_count = 0;
    int                check_count = 0;
    always #12.5 clock = ~clock;
    bwlm_top #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) DUT (
        .clock(clock), .rst(rst), .in_edge_pos(in_edge_pos), .in_edge_neg(in_edge_neg),
        .output_timing_pos(output_timing_pos), .output_timing_neg(output_timing_neg),
        .write_port_select_n(write_port_select_n), .read_port_select_n(read_port_select_n),
        .address(address), .write_data(write_data), .lane_write_mask_n(lane_write_mask_n),
        .read_data(read_data), .read_data_oe(read_data_oe), .single_clock_mode(single_clock_mode));
    bwlm_ctrl_model #(.DATA_W(DATA_W), .ADDR_W(ADDR_W), .LANE_N(LANE_N)) u_ctrl (
        .clock(clock), .read_data(read_data), .read_data_oe(read_data_oe),
        .in_edge_pos(in_edge_pos), .in_edge_neg(in_edge_neg),
        .output_timing_pos(output_timing_pos), .output_timing_neg(output_timing_neg),
        .write_port_select_n(write_port_select_n), .read_port_select_n(read_port_select_n),
        .address(address), .write_data(write_data), .lane_write_mask_n(lane_write_mask_n));
    // ------------------------------------------------------------------
    // Compare and bookkeeping tasks
    // ------------------------------------------------------------------
    task automatic give_verdict();
        if (err_count == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk_data(input string nm, input logic [DATA_W-1:0] e, g);
        check_count++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask
    task automatic chk_bit(input string nm, input logic e, g);
        check_count++;
        if (g !== e) begin
            $display("mismatch %s expected %b seen %b", nm, e, g);
            err_count++;
        end
    endtask
    task automatic do_reset(input logic strap);
        u_ctrl.park(strap);
        rst = 1'b1;
        repeat (2) @(posedge clock);
        #1;
        rst = 1'b0;
        u_ctrl.step(8);
        u_ctrl.park(1'b1);
        u_ctrl.step(4);
    endtask
    // Expected array honours each beat's selects
    task automatic wr_exp(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d0, d1,
                          input logic [LANE_N-1:0] m0, m1, input logic sel_n);
        u_ctrl.wr(a, d0, d1, m0, m1, sel_n);
        for (int i = 0; i < LANE_N; i++) begin
            if (!sel_n && !m0[i])
                exp_mem[a][0][i*LW +: LW] = d0[i*LW +: LW];
            if (!sel_n && !m1[i])
                exp_mem[a][1][i*LW +: LW] = d1[i*LW +: LW];
        end
    endtask
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic single);
        logic [DATA_W-1:0] q0, q1;
        logic [2:0]        oe;
        u_ctrl.rd(a, single, q0, q1, oe);
        chk_bit("oe_first", 1'b1, oe[0]);
        chk_data("beat0", exp_mem[a][0], q0);
        chk_bit("oe_second", 1'b1, oe[1]);
        chk_data("beat1", exp_mem[a][1], q1);
        chk_bit("oe_off", 1'b0, oe[2]);
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset(input logic single);
        chk_bit("oe_idle", 1'b0, read_data_oe);
        chk_bit("single_mode", single, single_clock_mode);
    endtask
    task automatic t_full();
        wr_exp(6'h05, 18'h12345, 18'h2fedc, 2'h0, 2'h0, 1'b0);
        rd_chk(6'h05, 1'b0);
    endtask
    // Every select pair; beat 1 gets the complement
    task automatic t_lanes();
        for (int k = 8; k < 12; k++) begin
            wr_exp(6'(k), 18'h15555, 18'h2aaaa, 2'h0, 2'h0, 1'b0);
            wr_exp(6'(k), 18'h0f0f0 ^ 18'(k), 18'h3c3c3, 2'(k), ~2'(k), 1'b0);
            rd_chk(6'(k), 1'b0);
        end
    endtask
    task automatic t_deselect();
        wr_exp(6'h05, 18'h3ffff, 18'h00000, 2'h0, 2'h0, 1'b1);
        rd_chk(6'h05, 1'b0);
    endtask
    task automatic t_single();
        do_reset(1'b1);
        t_reset(1'b1);
        wr_exp(6'h03, 18'h0abcd, 18'h3a5a5, 2'h0, 2'h0, 1'b0);
        rd_chk(6'h03, 1'b1);
    endtask
    initial begin
        do_reset(1'b0);
        t_reset(1'b0);
        t_full();
        t_lanes();
        t_deselect();
        t_single();
        give_verdict();
    end
    // Run takes about 500 cycles
    initial begin
        repeat (2000) @(posedge clock);
        err_count++;
        give_verdict();
    end
endmodule
bind bwlm_top bwlm_props #(.DATA_W(DATA_W), .ADDR_W(ADDR_W), .LANE_N(LANE_N)) u_props (
    .clock(clock), .rst(rst), .in_edge_pos(in_edge_pos), .in_edge_neg(in_edge_neg),
    .output_timing_pos(output_timing_pos), .output_timing_neg(output_timing_neg),
    .write_port_select_n(write_port_select_n), .read_port_select_n(read_port_select_n),
    .address(address), .write_data(write_data), .lane_write_mask_n(lane_write_mask_n),
    .read_data(read_data), .read_data_oe(read_data_oe), .single_clock_mode(single_clock_mode));
`default_nettype wire
